/* File: common/fcc_cfg.svh */
// offsets, field positions, reset values and response codes for the flow control configuration block
`ifndef FCC_CFG_SVH
`define FCC_CFG_SVH
`define FCC_ADDR_W 4
`define FCC_OFF_CONFIG 4'h0
`define FCC_OFF_STATUS 4'h4
`define FCC_BIT_TX_FC 30
`define FCC_BIT_RX_FC 29
`define FCC_BIT_PFC_TX 26
`define FCC_BIT_PFC_RX 25
`define FCC_BIT_AUTO_XON 20
`define FCC_TX_PRIO_LSB 8
`define FCC_RX_PRIO_LSB 0
`define FCC_WRITABLE_MASK 32'h6610FFFF
`define FCC_RESET_PFC 32'h6010FFFF
`define FCC_RESET_NOPFC 32'h60000000
`define FCC_RESP_OKAY 2'h0
`define FCC_RESP_SLVERR 2'h2
`endif

/* File: common/fcc_pkg.sv */
// types shared by the flow control configuration block
package fcc_pkg;
  typedef enum logic [1:0] {FCC_WR_IDLE, FCC_WR_RESP} fcc_wr_state_t;
  typedef enum logic [0:0] {FCC_RD_IDLE, FCC_RD_DATA} fcc_rd_state_t;
endpackage

/* File: logic/fcc_flow_ctrl.sv */
// flow control configuration register with axi4-lite access and pause request gating
`timescale 1ns/1ps
`include "fcc_cfg.svh"
module fcc_flow_ctrl #(
  parameter bit PFC_SUPPORT = 1'b1
) (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_nrst,
  // axi4-lite write address and data
  input wire logic [`FCC_ADDR_W-1:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  // axi4-lite write response
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  // axi4-lite read
  input wire logic [`FCC_ADDR_W-1:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  // client pause requests (same clock)
  input wire logic i_pause_request,
  input wire logic [7:0] i_tx_prio_hold_valid,
  // receive side pause detection from the mac receiver (same clock)
  input wire logic i_rx_pause_frame,
  input wire logic i_rx_pfc_frame,
  input wire logic [7:0] i_rx_pfc_quanta_nonzero,
  // actions towards transmitter and client
  output logic o_send_pause,
  output logic o_send_pause_xon,
  output logic o_send_pfc,
  output logic [7:0] o_send_pfc_xon,
  output logic o_tx_hold_off,
  output logic o_forward_pause,
  output logic o_forward_pfc,
  output logic [7:0] o_rx_prio_hold_valid,
  output logic [31:0] o_config
);

  ////////////////////////////////////////////////////////////////////////////
  // state
  typedef struct packed {
    logic [31:0] cfg;
    logic aw_got;
    logic [`FCC_ADDR_W-1:0] aw_addr;
    logic w_got;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    fcc_pkg::fcc_wr_state_t wr_st;
    logic [1:0] bresp;
    fcc_pkg::fcc_rd_state_t rd_st;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic pause_d;
    logic [7:0] prio_d;
    logic send_pause;
    logic send_xon;
    logic send_pfc;
    logic [7:0] pfc_xon;
    logic hold_off;
    logic fwd_pause;
    logic fwd_pfc;
    logic [7:0] rx_prio;
    logic awready;
    logic wready;
    logic bvalid;
    logic arready;
    logic rvalid;
  } fcc_state_t;

  fcc_state_t st;
  fcc_state_t next_st;
  logic [31:0] reset_cfg;
  logic [31:0] wr_mask;

  // reset value and writable bits depend on pfc support
  assign reset_cfg = PFC_SUPPORT ? `FCC_RESET_PFC : `FCC_RESET_NOPFC;
  assign wr_mask = PFC_SUPPORT ? `FCC_WRITABLE_MASK : (`FCC_WRITABLE_MASK & 32'h60000000);

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    logic [31:0] strb_bits;
    logic tx_fc;
    logic rx_fc;
    logic pfc_tx;
    logic pfc_rx;
    logic xon;
    logic [7:0] tx_en;
    logic [7:0] rx_en;
    logic [7:0] rise;
    logic [7:0] fall;
    strb_bits = '0;
    next_st = st;
    tx_fc = st.cfg[`FCC_BIT_TX_FC];
    rx_fc = st.cfg[`FCC_BIT_RX_FC];
    pfc_tx = st.cfg[`FCC_BIT_PFC_TX];
    pfc_rx = st.cfg[`FCC_BIT_PFC_RX];
    xon = st.cfg[`FCC_BIT_AUTO_XON];
    tx_en = st.cfg[`FCC_TX_PRIO_LSB +: 8];
    rx_en = st.cfg[`FCC_RX_PRIO_LSB +: 8];
    rise = i_tx_prio_hold_valid & ~st.prio_d;
    fall = ~i_tx_prio_hold_valid & st.prio_d;
    // write channel capture, either order
    if (st.wr_st == fcc_pkg::FCC_WR_IDLE) begin
      if (i_awvalid && !st.aw_got) begin
        next_st.aw_got = 1'b1;
        next_st.aw_addr = i_awaddr;
      end
      if (i_wvalid && !st.w_got) begin
        next_st.w_got = 1'b1;
        next_st.w_data = i_wdata;
        next_st.w_strb = i_wstrb;
      end
      if (st.aw_got && st.w_got) begin
        for (int b = 0; b < 4; b++) begin
          strb_bits[b*8 +: 8] = {8{st.w_strb[b]}};
        end
        if (st.aw_addr == `FCC_OFF_CONFIG) begin
          // reserved bits hold no state
          next_st.cfg = (st.cfg & ~(strb_bits & wr_mask)) | (st.w_data & strb_bits & wr_mask);
          next_st.bresp = `FCC_RESP_OKAY;
        end else if (st.aw_addr == `FCC_OFF_STATUS) begin
          next_st.bresp = `FCC_RESP_OKAY; // read-only, write ignored
        end else begin
          next_st.bresp = `FCC_RESP_SLVERR;
        end
        next_st.aw_got = 1'b0;
        next_st.w_got = 1'b0;
        next_st.wr_st = fcc_pkg::FCC_WR_RESP;
      end
    end else if (i_bready) begin
      next_st.wr_st = fcc_pkg::FCC_WR_IDLE;
    end
    // read channel
    unique case (st.rd_st)
      fcc_pkg::FCC_RD_IDLE: begin
        if (i_arvalid) begin
          next_st.rd_st = fcc_pkg::FCC_RD_DATA;
          next_st.rresp = `FCC_RESP_OKAY;
          if (i_araddr == `FCC_OFF_CONFIG) begin
            next_st.rdata = st.cfg;
          end else if (i_araddr == `FCC_OFF_STATUS) begin
            next_st.rdata = {14'h0000, st.hold_off, st.pause_d, st.prio_d, st.rx_prio};
          end else begin
            next_st.rdata = 32'h00000000;
            next_st.rresp = `FCC_RESP_SLVERR;
          end
        end
      end
      fcc_pkg::FCC_RD_DATA: begin
        if (i_rready) begin
          next_st.rd_st = fcc_pkg::FCC_RD_IDLE;
        end
      end
    endcase
    // standard pause transmit requests
    next_st.pause_d = i_pause_request;
    next_st.send_pause = tx_fc && i_pause_request && !st.pause_d;
    next_st.send_xon = tx_fc && xon && !i_pause_request && st.pause_d;
    // per-priority transmit requests, both edges
    next_st.prio_d = i_tx_prio_hold_valid;
    next_st.send_pfc = pfc_tx && (|((rise | fall) & tx_en));
    next_st.pfc_xon = (pfc_tx && xon) ? (fall & tx_en) : 8'h00;
    // receive side handling
    next_st.hold_off = rx_fc && i_rx_pause_frame;
    next_st.fwd_pause = !rx_fc && i_rx_pause_frame;
    next_st.fwd_pfc = !pfc_rx && i_rx_pfc_frame;
    if (pfc_rx && i_rx_pfc_frame) begin
      next_st.rx_prio = i_rx_pfc_quanta_nonzero & rx_en;
    end
    next_st.rx_prio = next_st.rx_prio & rx_en & {8{pfc_rx}};
    // handshake outputs registered from the next state, so no output is decoded
    next_st.awready = (next_st.wr_st == fcc_pkg::FCC_WR_IDLE) && !next_st.aw_got;
    next_st.wready = (next_st.wr_st == fcc_pkg::FCC_WR_IDLE) && !next_st.w_got;
    next_st.bvalid = (next_st.wr_st == fcc_pkg::FCC_WR_RESP);
    next_st.arready = (next_st.rd_st == fcc_pkg::FCC_RD_IDLE);
    next_st.rvalid = (next_st.rd_st == fcc_pkg::FCC_RD_DATA);
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      st <= '0;
      st.cfg <= reset_cfg;
      // both channels idle, so every ready leaves reset high
      st.awready <= 1'b1;
      st.wready <= 1'b1;
      st.arready <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign o_awready = st.awready;
  assign o_wready = st.wready;
  assign o_bvalid = st.bvalid;
  assign o_bresp = st.bresp;
  assign o_arready = st.arready;
  assign o_rvalid = st.rvalid;
  assign o_rdata = st.rdata;
  assign o_rresp = st.rresp;
  assign o_send_pause = st.send_pause;
  assign o_send_pause_xon = st.send_xon;
  assign o_send_pfc = st.send_pfc;
  assign o_send_pfc_xon = st.pfc_xon;
  assign o_tx_hold_off = st.hold_off;
  assign o_forward_pause = st.fwd_pause;
  assign o_forward_pfc = st.fwd_pfc;
  assign o_rx_prio_hold_valid = st.rx_prio;
  assign o_config = st.cfg;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking fcc_cb @(posedge i_clock); endclocking
  default disable iff (!i_nrst);

  sequence s_pause_rise;
    i_pause_request && !st.pause_d;
  endsequence

  property p_tx_pause_sent;
    s_pause_rise and st.cfg[`FCC_BIT_TX_FC] |=> o_send_pause;
  endproperty
  a_tx_pause_sent: assert property (p_tx_pause_sent) else $error("pause frame not requested");

  property p_tx_pause_ignored;
    !st.cfg[`FCC_BIT_TX_FC] |=> !o_send_pause && !o_send_pause_xon;
  endproperty
  a_tx_pause_ignored: assert property (p_tx_pause_ignored) else $error("pause sent while disabled");

  property p_hold_off;
    i_rx_pause_frame |=> (o_tx_hold_off == $past(st.cfg[`FCC_BIT_RX_FC])) && (o_forward_pause != o_tx_hold_off);
  endproperty
  a_hold_off: assert property (p_hold_off) else $error("pause frame handling wrong");

  property p_pfc_tx;
    (|((i_tx_prio_hold_valid ^ st.prio_d) & st.cfg[15:8])) && st.cfg[`FCC_BIT_PFC_TX] |=> o_send_pfc;
  endproperty
  a_pfc_tx: assert property (p_pfc_tx) else $error("pfc frame not requested");

  property p_pfc_tx_off;
    !st.cfg[`FCC_BIT_PFC_TX] |=> !o_send_pfc && (o_send_pfc_xon == 8'h00);
  endproperty
  a_pfc_tx_off: assert property (p_pfc_tx_off) else $error("pfc sent while disabled");

  property p_pfc_xon;
    st.cfg[`FCC_BIT_PFC_TX] && st.cfg[`FCC_BIT_AUTO_XON] |=>
      o_send_pfc_xon == $past(st.prio_d & ~i_tx_prio_hold_valid & st.cfg[15:8]);
  endproperty
  a_pfc_xon: assert property (p_pfc_xon) else $error("priority resume frame wrong");

  property p_pfc_rx;
    i_rx_pfc_frame && st.cfg[`FCC_BIT_PFC_RX] |=> o_rx_prio_hold_valid == $past(i_rx_pfc_quanta_nonzero & st.cfg[7:0]);
  endproperty
  a_pfc_rx: assert property (p_pfc_rx) else $error("priority pause outputs wrong");

  property p_pfc_fwd;
    i_rx_pfc_frame && !st.cfg[`FCC_BIT_PFC_RX] |=> o_forward_pfc && o_rx_prio_hold_valid == 8'h00;
  endproperty
  a_pfc_fwd: assert property (p_pfc_fwd) else $error("pfc frame not forwarded");

  property p_rx_prio_mask;
    ##1 (o_rx_prio_hold_valid & ~$past(st.cfg[7:0])) == 8'h00;
  endproperty
  a_rx_prio_mask: assert property (p_rx_prio_mask) else $error("disabled priority asserted");

  property p_xon;
    !i_pause_request && st.pause_d && st.cfg[`FCC_BIT_TX_FC] && st.cfg[`FCC_BIT_AUTO_XON] |=> o_send_pause_xon;
  endproperty
  a_xon: assert property (p_xon) else $error("resume frame missing");

  property p_reserved;
    (st.cfg & ~wr_mask) == 32'h00000000;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits hold state");

endmodule // fcc_flow_ctrl

/* File: verif/fcc_client.sv */
// client and receiver stimulus model facing the flow control block
`timescale 1ns/1ps
module fcc_client (
  // clock
  input wire logic i_clock,
  // pause requests and receive events
  output logic o_pause_request,
  output logic [7:0] o_tx_prio,
  output logic o_rx_pause,
  output logic o_rx_pfc,
  output logic [7:0] o_quanta
);
  // idle levels at time zero
  initial begin
    o_pause_request = 1'b0;
    o_tx_prio = 8'h00;
    o_rx_pause = 1'b0;
    o_rx_pfc = 1'b0;
    o_quanta = 8'h00;
  end
  // request levels change just after an edge
  task automatic req(input logic p, input logic [7:0] pr);
    @(posedge i_clock);
    o_pause_request <= p;
    o_tx_prio <= pr;
  endtask
  // one-cycle receive event
  task automatic rx(input logic pause, input logic pfc, input logic [7:0] q);
    @(posedge i_clock);
    o_rx_pause <= pause;
    o_rx_pfc <= pfc;
    o_quanta <= q;
    @(posedge i_clock);
    o_rx_pause <= 1'b0;
    o_rx_pfc <= 1'b0;
    o_quanta <= ~q; // quanta flags mean nothing outside the pulse
  endtask
endmodule // fcc_client

/* File: verif/testbench.sv */
// self-checking bench for the flow control configuration block
`timescale 1ns/1ps
module testbench;
  logic i_clock = 1'b0;
  logic i_nrst = 1'b0;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic awready, wready, bvalid, arready, rvalid, sp, sx, spfc, hold, fp, ff, preq, rxp, rxpfc;
  logic [1:0] bresp, rresp, resp;
  logic [31:0] rdata, cfg, rv;
  logic [7:0] pxon, rx_prio, tx_prio, quanta, xs;
  logic [31:0] cnt [6];
  logic [5:0] pulses;
  assign pulses = {ff, fp, hold, spfc, sx, sp};
  int n_mismatch = 0, cmp_count = 0, cyc = 0;
  ////////////////////////////////////////////////////////////
  always #2.5 i_clock = ~i_clock;
  fcc_flow_ctrl dut (.i_clock(i_clock), .i_nrst(i_nrst), .i_awaddr(awaddr), .i_awvalid(awvalid),
    .o_awready(awready), .i_wdata(wdata), .i_wstrb(4'hF), .i_wvalid(wvalid), .o_wready(wready),
    .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid),
    .o_arready(arready), .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready),
    .i_pause_request(preq), .i_tx_prio_hold_valid(tx_prio), .i_rx_pause_frame(rxp),
    .i_rx_pfc_frame(rxpfc), .i_rx_pfc_quanta_nonzero(quanta), .o_send_pause(sp), .o_send_pause_xon(sx),
    .o_send_pfc(spfc), .o_send_pfc_xon(pxon), .o_tx_hold_off(hold), .o_forward_pause(fp),
    .o_forward_pfc(ff), .o_rx_prio_hold_valid(rx_prio), .o_config(cfg));
  fcc_client cl (.i_clock(i_clock), .o_pause_request(preq), .o_tx_prio(tx_prio), .o_rx_pause(rxp),
    .o_rx_pfc(rxpfc), .o_quanta(quanta));
  ////////////////////////////////////////////////////////////
  // tally output pulses, cut a hang short
  always @(posedge i_clock) begin
    for (int k = 0; k < 6; k++) cnt[k] += {31'h0, pulses[k]};
    xs |= pxon;
    cyc++;
    if (cyc == 4000) begin
      n_mismatch++;
      end_sim();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // axi4-lite write, address and data offered together
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge i_clock);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge i_clock);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    resp = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge i_clock);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge i_clock);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rv = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask
  // clear tallies away from the edge
  task automatic clr();
    @(negedge i_clock);
    cnt = '{default: 32'h0};
    xs = 8'h00;
  endtask
  ////////////////////////////////////////////////////////////
  task automatic t_reg();
    rd(4'h0);
    chk(rv, 32'h6010FFFF);
    chk({30'h0, resp}, 32'h0);
    wr(4'h0, 32'hB5EFFFFF);
    chk({30'h0, resp}, 32'h0);
    wr(4'h8, 32'hFFFFFFFF);
    chk({30'h0, resp}, 32'h2);
    rd(4'h0);
    chk(rv, 32'h2400FFFF);
    chk(cfg, 32'h2400FFFF);
    rd(4'h8);
    chk({30'h0, resp}, 32'h2);
    wr(4'h0, 32'h6010FFFF);
    $display("test reg done");
  endtask
  task automatic t_std();
    clr();
    cl.rx(1'b1, 1'b0, 8'h00);
    cl.req(1'b1, 8'h00);
    cl.req(1'b0, 8'h00);
    repeat (4) @(posedge i_clock);
    chk(cnt[3], 32'h1);
    chk(cnt[4], 32'h0);
    chk(cnt[0], 32'h1);
    chk(cnt[1], 32'h1);
    wr(4'h0, 32'h00100000);
    clr();
    cl.rx(1'b1, 1'b0, 8'h00);
    cl.req(1'b1, 8'h00);
    cl.req(1'b0, 8'h00);
    repeat (4) @(posedge i_clock);
    chk(cnt[4], 32'h1);
    chk(cnt[3], 32'h0);
    chk(cnt[0] + cnt[1], 32'h0);
    $display("test std done");
  endtask
  task automatic t_pfc_tx();
    wr(4'h0, 32'h04100800);
    clr();
    cl.req(1'b0, 8'h08);
    cl.req(1'b0, 8'h00);
    cl.req(1'b0, 8'h04);
    cl.req(1'b0, 8'h00);
    repeat (4) @(posedge i_clock);
    chk(cnt[2], 32'h2);
    chk({24'h0, xs}, 32'h08);
    wr(4'h0, 32'h00100800);
    clr();
    cl.req(1'b0, 8'hFF);
    cl.req(1'b0, 8'h00);
    repeat (4) @(posedge i_clock);
    chk(cnt[2], 32'h0);
    chk({24'h0, xs}, 32'h0);
    $display("test pfc_tx done");
  endtask
  task automatic t_pfc_rx();
    wr(4'h0, 32'h0200000F);
    clr();
    cl.rx(1'b0, 1'b1, 8'hFF);
    repeat (4) @(posedge i_clock);
    chk({24'h0, rx_prio}, 32'h0F);
    chk(cnt[5], 32'h0);
    rd(4'h4);
    chk(rv, 32'h0000000F);
    wr(4'h0, 32'h00000000);
    @(posedge i_clock);
    chk({24'h0, rx_prio}, 32'h0);
    clr();
    cl.rx(1'b0, 1'b1, 8'hFF);
    repeat (4) @(posedge i_clock);
    chk(cnt[5], 32'h1);
    $display("test pfc_rx done");
  endtask
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge i_clock);
    i_nrst <= 1'b1;
    t_reg();
    t_std();
    t_pfc_tx();
    t_pfc_rx();
    end_sim();
  end
endmodule // testbench
